// [src/ccs_cfg.svh]
// Register offsets, field positions, reset values and timing counts for CPU clock select
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH
`define CCS_PCC_ADDR 16'hfffb
`define CCS_OSCILLATION_MODE_SELECT_ADDR 16'hfff2
`define CCS_PCC_RESET 8'h04
`define CCS_OSCILLATION_MODE_SELECT_RESET 8'h00
`define CCS_BIT_STOP 7
`define CCS_BIT_FRSEL 6
`define CCS_BIT_STAT 5
`define CCS_BIT_SRC 4
`define CCS_DIV_MSB 2
`define CCS_DIV_MAX 3'h4
`define CCS_LAT_MAIN 8'h10
`define CCS_LAT_SUB 8'h01
`define CCS_STRETCH_OSC 2
`endif

// [src/ccs_pkg.sv]
// Types for CPU clock select
package ccs_pkg;
  typedef struct packed {
    logic osc_stop;
    logic fb_res_off;
    logic src_sub;
    logic [2:0] div;
  } ccs_sel_t;
  typedef enum logic [0:0] {
    CCS_IDLE = 1'b0,
    CCS_WAIT = 1'b1
  } ccs_state_t;
endpackage : ccs_pkg

// [src/ccs_clock_select.sv]
// CPU clock selection: registers, switch latency and clock enables
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ccs_cfg.svh"
// Summary of operation
// - After a control write that changes source or divisor, the old clock runs on during a latency period.
// - Latency is 16 old instructions between divisors, 1 toward subsystem clock.
// - One write may return to main clock and change divisor together.
// - Control register: 8 bits, FFFBH, reset 04H, stop/resistor/status/source/0/divisor.
// - Divisor 0..4 gives main clock over 1..16; source 1 gives subsystem/2.
// - Main clock equals oscillator when bypass is 1, half oscillator when 0.
// - Status bit is read-only: 0 on main clock, 1 on subsystem clock.
// - Resistor select 0 enables feedback resistor, 1 disconnects it.
// - Stop bit 0 lets main oscillator run, 1 halts it.
// - Mode register: write-only, FFF2H, reset 00H, bit 0 bypasses the divider.
// - Any mode register write stretches the main clock cycle by two osc periods.
module ccs_clock_select (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock sources, one-cycle ticks on clk_sys
  input wire logic osc_tick,
  input wire logic sub_tick,
  // Clock control outputs
  output logic cpu_clk_en,
  output logic main_osc_stop,
  output logic feedback_resistor_select,
  output logic active_clock_status,
  output logic divider_bypass,
  output logic switching
);
  // ==========================================================
  // Register bus
  logic wr_pend;
  logic next_wr_pend;
  logic [15:0] wr_addr;
  logic [15:0] next_wr_addr;
  logic [31:0] next_hrdata;
  ccs_pkg::ccs_sel_t req;
  ccs_pkg::ccs_sel_t next_req;
  ccs_pkg::ccs_sel_t act;
  ccs_pkg::ccs_sel_t next_act;
  logic bypass;
  logic next_bypass;
  logic pcc_wr;
  logic oscillation_mode_select_wr;
  logic [7:0] pcc_rd;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pcc_wr = wr_pend && wr_addr == `CCS_PCC_ADDR;
  assign oscillation_mode_select_wr = wr_pend && wr_addr == `CCS_OSCILLATION_MODE_SELECT_ADDR;
  // Read view: status shows the clock really in use
  assign pcc_rd = {req.osc_stop, req.fb_res_off, act.src_sub, req.src_sub, 1'b0, req.div};

  always_comb begin
    next_wr_pend = hsel && hready && htrans[1] && hwrite;
    next_wr_addr = hready ? haddr[15:0] : wr_addr;
    next_hrdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite && haddr[15:0] == `CCS_PCC_ADDR) begin
      next_hrdata = {24'h00_0000, pcc_rd};
    end
    next_req = req;
    next_bypass = bypass;
    if (pcc_wr) begin
      next_req.osc_stop = hwdata[`CCS_BIT_STOP];
      next_req.fb_res_off = hwdata[`CCS_BIT_FRSEL];
      next_req.src_sub = hwdata[`CCS_BIT_SRC];
      next_req.div = hwdata[`CCS_DIV_MSB:0];
    end
    if (oscillation_mode_select_wr) begin
      next_bypass = hwdata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      wr_addr <= 16'h0000;
      hrdata <= 32'h0000_0000;
      req <= ccs_pkg::ccs_sel_t'({1'b0, 1'b0, 1'b0, 3'h4});
      bypass <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      req <= next_req;
      bypass <= next_bypass;
    end
  end

  assign main_osc_stop = req.osc_stop;
  assign feedback_resistor_select = req.fb_res_off;
  assign divider_bypass = bypass;
  assign active_clock_status = act.src_sub;

  // ==========================================================
  // Clock enable generation
  logic main_phase;
  logic next_main_phase;
  logic sub_phase;
  logic next_sub_phase;
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic [1:0] stretch;
  logic [1:0] next_stretch;
  logic main_tick;

  function automatic logic [3:0] ccs_div_mask(input logic [2:0] d);
    ccs_div_mask = 4'((5'h01 << d) - 5'h01);
  endfunction : ccs_div_mask

  // Main tick: every osc tick with bypass, every second without; held for two osc ticks after a mode write
  assign main_tick = osc_tick && !req.osc_stop && stretch == 2'h0 &&
                     (bypass || main_phase);

  always_comb begin
    next_main_phase = main_phase ^ osc_tick;
    next_sub_phase = sub_phase ^ sub_tick;
    next_stretch = stretch;
    if (oscillation_mode_select_wr) begin
      next_stretch = 2'(`CCS_STRETCH_OSC);
    end else if (osc_tick && stretch != 2'h0) begin
      next_stretch = stretch - 2'h1;
    end
    next_div_cnt = div_cnt;
    cpu_clk_en = 1'b0;
    if (act.src_sub) begin
      cpu_clk_en = sub_tick && sub_phase;
    end else if (main_tick) begin
      if ((div_cnt & ccs_div_mask(act.div)) == ccs_div_mask(act.div)) begin
        cpu_clk_en = 1'b1;
        next_div_cnt = 4'h0;
      end else begin
        next_div_cnt = div_cnt + 4'h1;
      end
    end
  end

  // ==========================================================
  // Switch latency
  ccs_pkg::ccs_state_t state;
  ccs_pkg::ccs_state_t next_state;
  logic [7:0] lat;
  logic [7:0] next_lat;
  logic instr_tick;
  logic next_instr_tick;
  logic instr_half;
  logic next_instr_half;

  assign switching = state == ccs_pkg::CCS_WAIT;

  always_comb begin
    // One instruction is two CPU clocks of the old setting
    next_instr_half = cpu_clk_en ? !instr_half : instr_half;
    next_instr_tick = cpu_clk_en && instr_half;
    next_state = state;
    next_lat = lat;
    next_act = act;
    unique case (state)
      ccs_pkg::CCS_IDLE: begin
        if (req.src_sub != act.src_sub || req.div != act.div) begin
          next_state = ccs_pkg::CCS_WAIT;
          next_lat = (req.src_sub && !act.src_sub) ? `CCS_LAT_SUB : `CCS_LAT_MAIN;
        end
      end
      ccs_pkg::CCS_WAIT: begin
        if (instr_tick) begin
          next_lat = lat - 8'h01;
        end
        if (instr_tick && lat == 8'h01) begin
          // Source and divisor move together, main return included
          next_act.src_sub = req.src_sub;
          next_act.div = (req.div > `CCS_DIV_MAX) ? act.div : req.div;
          next_state = ccs_pkg::CCS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      main_phase <= 1'b0;
      sub_phase <= 1'b0;
      div_cnt <= 4'h0;
      stretch <= 2'h0;
      state <= ccs_pkg::CCS_IDLE;
      lat <= 8'h00;
      act <= ccs_pkg::ccs_sel_t'({1'b0, 1'b0, 1'b0, 3'h4});
      instr_tick <= 1'b0;
      instr_half <= 1'b0;
    end else begin
      main_phase <= next_main_phase;
      sub_phase <= next_sub_phase;
      div_cnt <= next_div_cnt;
      stretch <= next_stretch;
      state <= next_state;
      lat <= next_lat;
      act <= next_act;
      instr_tick <= next_instr_tick;
      instr_half <= next_instr_half;
    end
  end

  // ==========================================================
  // Assertions
  property p_hold_old;
    @(posedge clk_sys) disable iff (!nrst)
    (state == ccs_pkg::CCS_WAIT && !instr_tick) |=> $stable(act);
  endproperty
  a_hold_old: assert property (p_hold_old) else $error("Clock changed before latency end");

  property p_lat_load;
    @(posedge clk_sys) disable iff (!nrst)
    (state == ccs_pkg::CCS_IDLE && req.src_sub && !act.src_sub) |=> lat == 8'h01;
  endproperty
  a_lat_load: assert property (p_lat_load) else $error("Subsystem latency not one");

  property p_lat_main;
    @(posedge clk_sys) disable iff (!nrst)
    (state == ccs_pkg::CCS_IDLE && !req.src_sub && req.div != act.div) |=> lat == 8'h10;
  endproperty
  a_lat_main: assert property (p_lat_main) else $error("Divisor latency not sixteen");

  property p_status;
    @(posedge clk_sys) disable iff (!nrst)
    $changed(active_clock_status) |-> $past(state) == ccs_pkg::CCS_WAIT && $past(instr_tick);
  endproperty
  a_status: assert property (p_status) else $error("Status moved without switch");

  property p_read_pcc;
    @(posedge clk_sys) disable iff (!nrst)
    (hsel && hready && htrans[1] && !hwrite && haddr[15:0] == 16'hfffb)
      |=> hrdata[5] == $past(act.src_sub) && hrdata[3] == 1'b0;
  endproperty
  a_read_pcc: assert property (p_read_pcc) else $error("Control read wrong");

  property p_stop;
    @(posedge clk_sys) disable iff (!nrst)
    pcc_wr |=> main_osc_stop == $past(hwdata[7]) && feedback_resistor_select == $past(hwdata[6]);
  endproperty
  a_stop: assert property (p_stop) else $error("Stop or resistor bit not taken");

  property p_stretch;
    @(posedge clk_sys) disable iff (!nrst)
    oscillation_mode_select_wr |=> !main_tick;
  endproperty
  a_stretch: assert property (p_stretch) else $error("Main tick during mode write");

  property p_bypass;
    @(posedge clk_sys) disable iff (!nrst)
    oscillation_mode_select_wr |=> divider_bypass == $past(hwdata[0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass bit not taken");

  property p_switch_start;
    @(posedge clk_sys) disable iff (!nrst)
    (state == ccs_pkg::CCS_IDLE && (req.src_sub != act.src_sub || req.div != act.div))
      |=> switching;
  endproperty
  a_switch_start: assert property (p_switch_start) else $error("Switch not started");

  property p_osc_halt;
    @(posedge clk_sys) disable iff (!nrst)
    main_osc_stop |-> !main_tick;
  endproperty
  a_osc_halt: assert property (p_osc_halt) else $error("Main tick while stopped");

  property p_sub_clk;
    @(posedge clk_sys) disable iff (!nrst)
    (act.src_sub && cpu_clk_en) |-> sub_tick;
  endproperty
  a_sub_clk: assert property (p_sub_clk) else $error("CPU edge off subsystem tick");

  property p_half_main;
    @(posedge clk_sys) disable iff (!nrst)
    (!divider_bypass && main_tick) |-> main_phase;
  endproperty
  a_half_main: assert property (p_half_main) else $error("Main tick not halved");

  property p_status_ro;
    @(posedge clk_sys) disable iff (!nrst)
    (pcc_wr && state == ccs_pkg::CCS_IDLE) |=> $stable(active_clock_status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("Status moved by write");

  property p_div_legal;
    @(posedge clk_sys) disable iff (!nrst)
    act.div <= `CCS_DIV_MAX;
  endproperty
  a_div_legal: assert property (p_div_legal) else $error("Prohibited divisor in use");
endmodule : ccs_clock_select

// [verification/ccs_clock_select_tb_top.sv]
// Self-checking testbench for CPU clock select
`timescale 1ns/1ps
`include "ccs_cfg.svh"
module ccs_clock_select_tb_top;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic osc_tick = 1'b1;
  logic sub_tick = 1'b0;
  logic [1:0] sub_cnt = 2'h0;
  logic cpu_clk_en, main_osc_stop, feedback_resistor_select;
  logic active_clock_status, divider_bypass, switching;
  logic [31:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;
  int p;
  localparam logic [31:0] A_PCC = {16'h0000, `CCS_PCC_ADDR};
  localparam logic [31:0] A_OSCILLATION_MODE_SELECT = {16'h0000, `CCS_OSCILLATION_MODE_SELECT_ADDR};
  // ==========================================================
  // Clock, subsystem ticks every 4 cycles, design
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    sub_cnt <= sub_cnt + 2'h1;
    sub_tick <= (sub_cnt == 2'h3);
  end
  ccs_clock_select ccs_clock_select_inst (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_tick(osc_tick), .sub_tick(sub_tick), .cpu_clk_en(cpu_clk_en),
    .main_osc_stop(main_osc_stop), .feedback_resistor_select(feedback_resistor_select),
    .active_clock_status(active_clock_status), .divider_bypass(divider_bypass),
    .switching(switching));
  // ==========================================================
  // Tasks
  task automatic finish_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask : bus
  task automatic period(output int n);
    int w;
    w = 0;
    do begin @(posedge clk_sys); #1; w++; end while (cpu_clk_en !== 1'b1 && w < 500);
    n = 0;
    do begin @(posedge clk_sys); #1; n++; end while (cpu_clk_en !== 1'b1 && n < 500);
  endtask : period
  // Write, see switching start, then bound the old-clock edges spent switching
  task automatic wr_sw(input logic [31:0] a, input logic [7:0] wd, input int max_en);
    int en;
    int c;
    bus(1'b1, a, wd);
    @(posedge clk_sys);
    #1;
    chk({31'h0, switching}, 32'h1, "switching started");
    en = 0;
    c = 0;
    while (switching === 1'b1 && c < 4000) begin
      if (cpu_clk_en === 1'b1) en++;
      @(posedge clk_sys);
      #1;
      c++;
    end
    chk({31'h0, en <= max_en && c < 4000}, 32'h1, "switch latency");
  endtask : wr_sw
  // ==========================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, A_PCC, 8'h00);
    chk(rd, 32'h04, "control reset");
    bus(1'b0, A_OSCILLATION_MODE_SELECT, 8'h00);
    chk(rd, 32'h00, "mode read");
    chk({31'h0, divider_bypass}, 32'h0, "bypass reset");
    period(p);
    chk(p, 32, "fx/2 over 16");
    bus(1'b1, A_OSCILLATION_MODE_SELECT, 8'h01);
    @(posedge clk_sys);
    #1;
    chk({31'h0, divider_bypass}, 32'h1, "bypass set");
    bus(1'b0, A_OSCILLATION_MODE_SELECT, 8'h00);
    chk(rd, 32'h00, "mode write-only");
    for (int d = 3; d >= 0; d--) begin
      wr_sw(A_PCC, 8'(d), 32);
      period(p);
      chk(p, 1 << d, "main divisor period");
    end
    bus(1'b1, A_PCC, 8'h10);
    @(posedge clk_sys);
    #1;
    chk({31'h0, active_clock_status}, 32'h0, "status before switch");
    while (switching === 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    chk({31'h0, active_clock_status}, 32'h1, "status on sub");
    bus(1'b1, A_PCC, 8'hd0);
    @(posedge clk_sys);
    #1;
    chk({31'h0, switching}, 32'h0, "no switch on stop write");
    chk({30'h0, main_osc_stop, feedback_resistor_select}, 32'h3, "stop and res");
    period(p);
    chk(p, 8, "sub over 2");
    bus(1'b0, A_PCC, 8'h00);
    chk(rd, 32'hf0, "control on sub");
    wr_sw(A_PCC, 8'h2a, 32);
    bus(1'b0, A_PCC, 8'h00);
    chk(rd, 32'h02, "back to main with divisor");
    period(p);
    chk(p, 4, "main over 4");
    bus(1'b1, 32'h0000fff0, 8'hff);
    bus(1'b0, 32'h0000fff0, 8'h00);
    chk(rd, 32'h00, "unmapped read");
    bus(1'b0, A_PCC, 8'h00);
    chk(rd, 32'h02, "unmapped write ignored");
    bus(1'b1, A_OSCILLATION_MODE_SELECT, 8'h00);
    repeat (4) @(posedge clk_sys);
    period(p);
    chk(p, 8, "fx/2 over 4");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end
endmodule : ccs_clock_select_tb_top
